// file: design/pulse_timer_module.sv
// Pulse timer module: 16-bit counter, channels with capture, compare,
// edge and center PWM, flags with two-step clear, APB registers.
// Assumes pins synchronous to CLK and a divider-based counter clock.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_timer_params.svh"
module pulse_timer_module #(
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire pwm_timer_pkg::apb_req_t APB_REQ,
  output pwm_timer_pkg::apb_rsp_t APB_RSP,
  // Fixed and external counter clock enables
  input wire logic FIXED_TICK,
  input wire logic EXT_TICK,
  // Channel pins
  input wire logic [NCH-1:0] CH_IN,
  output logic [NCH-1:0] CH_OUT,
  output logic [NCH-1:0] CH_OE,
  // Interrupt requests
  output logic WRAP_IRQ,
  output logic [NCH-1:0] CHAN_IRQ
);
  import pwm_timer_pkg::*;

  typedef struct packed {
    logic [7:0] sc;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic [7:0] mod_hold;
    logic down;
    logic [6:0] ps;
    logic wrap_armed;
    logic [NCH-1:0][5:0] csc;
    logic [NCH-1:0] cflag;
    logic [NCH-1:0] carmed;
    logic [NCH-1:0][15:0] cval;
    logic [NCH-1:0][15:0] cbuf;
    logic [NCH-1:0] hi_wr;
    logic [NCH-1:0] lo_wr;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] pin_d;
    logic [NCH-1:0] pout;
    logic [NCH-1:0] poe;
    logic wrap_irq;
    logic [NCH-1:0] chan_irq;
    apb_rsp_t rsp;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic [15:0] sel_byte(input logic [15:0] w, input logic hi);
    sel_byte = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : sel_byte

  logic access;
  logic wr;
  logic rd;
  logic tick;
  logic [15:0] term;
  logic at_term;
  logic [1:0] clks;
  logic center;
  logic [15:0] cnt_next;
  logic [11:0] choff;
  logic [7:0] wb;
  logic [31:0] rdat;
  logic hit;

  always_comb begin
    s_nxt = s_r;
    access = APB_REQ.psel && APB_REQ.penable;
    wr = access && APB_REQ.pwrite;
    rd = access && !APB_REQ.pwrite;
    wb = APB_REQ.pwdata[7:0];
    clks = s_r.sc[`SC_CLKS_HI:`SC_CLKS_LO];
    center = s_r.sc[`SC_CENTER];
    // Prescaler divides the bus clock source by 2^ps; fixed and external ticks are not divided
    tick = 1'b0;
    case (clks)
      2'b01: tick = (s_r.ps & ((7'h01 << s_r.sc[`SC_PS_HI:`SC_PS_LO]) - 7'h01)) == 7'h00;
      2'b10: tick = FIXED_TICK;
      2'b11: tick = EXT_TICK;
      default: tick = 1'b0;
    endcase
    if (clks == 2'b01) begin
      s_nxt.ps = s_r.ps + 7'h01;
    end
    term = (s_r.modv == 16'h0000) ? 16'hffff : s_r.modv;
    at_term = s_r.cnt == term;
    cnt_next = s_r.cnt;
    rdat = 32'h0;
    hit = 1'b0;
    choff = 12'h000;
    // Counter step and compare events, gated by the tick; capture is not
    if (tick) begin
      if (!center) begin
        cnt_next = at_term ? 16'h0000 : s_r.cnt + 16'h0001;
        if (at_term) begin
          s_nxt.sc[`SC_FLAG] = 1'b1;
          s_nxt.wrap_armed = 1'b0;
        end
      end else begin
        if (!s_r.down && at_term) begin
          s_nxt.down = 1'b1;
          cnt_next = s_r.cnt - 16'h0001;
          s_nxt.sc[`SC_FLAG] = 1'b1;
          s_nxt.wrap_armed = 1'b0;
        end else if (s_r.down && s_r.cnt == 16'h0000) begin
          s_nxt.down = 1'b0;
          cnt_next = 16'h0001;
        end else begin
          cnt_next = s_r.down ? s_r.cnt - 16'h0001 : s_r.cnt + 16'h0001;
        end
      end
      s_nxt.cnt = cnt_next;
    end
    if (!center) begin
      s_nxt.down = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      // Capture edges are seen on every clock, the counter is only sampled
      s_nxt.pin_d[i] = CH_IN[i];
      if (center) begin
        s_nxt.poe[i] = s_r.csc[i][`CSC_ELS_HI:`CSC_ELS_LO] != 2'b00;
        if (tick && s_r.cval[i] != 16'h0000 && !s_r.cval[i][15]) begin
          if (cnt_next == s_r.cval[i]) begin
            // Match while climbing ends the active part, falling starts it
            s_nxt.pout[i] = s_r.down ^ s_r.csc[i][`CSC_ELS_LO];
            s_nxt.cflag[i] = 1'b1;
            s_nxt.carmed[i] = 1'b0;
          end
        end
        if (s_r.cval[i] == 16'h0000 || s_r.cval[i][15]) begin
          s_nxt.pout[i] = s_r.csc[i][`CSC_ELS_LO];
        end else if (s_r.modv != 16'h0000 && s_r.cval[i] > s_r.modv) begin
          // No match ever comes, so the pin must be forced active
          s_nxt.pout[i] = !s_r.csc[i][`CSC_ELS_LO];
        end
      end else begin
        case (s_r.csc[i][`CSC_MS_HI:`CSC_MS_LO])
          2'b00: begin
            s_nxt.poe[i] = 1'b0;
            if ((s_r.csc[i][`CSC_ELS_LO] && CH_IN[i] && !s_r.pin_d[i]) ||
                (s_r.csc[i][`CSC_ELS_HI] && !CH_IN[i] && s_r.pin_d[i])) begin
              s_nxt.cval[i] = s_r.cnt;
              s_nxt.cflag[i] = 1'b1;
              s_nxt.carmed[i] = 1'b0;
            end
          end
          2'b01: begin
            s_nxt.poe[i] = s_r.csc[i][`CSC_ELS_HI:`CSC_ELS_LO] != 2'b00;
            if (tick && cnt_next == s_r.cval[i]) begin
              s_nxt.cflag[i] = 1'b1;
              s_nxt.carmed[i] = 1'b0;
              case (s_r.csc[i][`CSC_ELS_HI:`CSC_ELS_LO])
                2'b01: s_nxt.pout[i] = !s_r.pout[i];
                2'b10: s_nxt.pout[i] = 1'b0;
                2'b11: s_nxt.pout[i] = 1'b1;
                default: s_nxt.pout[i] = s_r.pout[i];
              endcase
            end
          end
          default: begin
            // Edge PWM on the plain up counter, shareable with other modes
            s_nxt.poe[i] = s_r.csc[i][`CSC_ELS_HI:`CSC_ELS_LO] != 2'b00;
            if (tick) begin
              if (at_term) begin
                s_nxt.pout[i] = (s_r.cval[i] != 16'h0000) ^ s_r.csc[i][`CSC_ELS_LO];
              end else if (cnt_next == s_r.cval[i]) begin
                s_nxt.pout[i] = s_r.csc[i][`CSC_ELS_LO];
                s_nxt.cflag[i] = 1'b1;
                s_nxt.carmed[i] = 1'b0;
              end
            end
          end
        endcase
      end
      // Buffered value loads one step before the terminal count
      if (s_r.pend[i] && clks != 2'b00 && tick && !center &&
          s_r.csc[i][`CSC_MS_HI:`CSC_MS_LO] != 2'b00 && cnt_next == term) begin
        s_nxt.cval[i] = s_r.cbuf[i];
        s_nxt.pend[i] = 1'b0;
      end else if (s_r.pend[i] && clks != 2'b00 && tick && center && !s_r.down &&
                   cnt_next == term) begin
        s_nxt.cval[i] = s_r.cbuf[i];
        s_nxt.pend[i] = 1'b0;
      end
    end
    // APB register access, zero wait states
    s_nxt.rsp.pready = 1'b1;
    s_nxt.rsp.pslverr = 1'b0;
    if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
      case (APB_REQ.paddr)
        `OFF_SC: begin
          rdat = {24'h0, s_r.sc};
          if (s_r.sc[`SC_FLAG]) begin
            s_nxt.wrap_armed = 1'b1;
          end
        end
        `OFF_CNTH: rdat = {16'h0, sel_byte(s_r.cnt, 1'b1)};
        `OFF_CNTL: rdat = {16'h0, sel_byte(s_r.cnt, 1'b0)};
        `OFF_MODH: rdat = {16'h0, sel_byte(s_r.modv, 1'b1)};
        `OFF_MODL: rdat = {16'h0, sel_byte(s_r.modv, 1'b0)};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            choff = `OFF_CH_BASE + 12'(i) * `CH_STRIDE;
            if (APB_REQ.paddr == choff + `CH_SC) begin
              rdat = {24'h0, s_r.cflag[i], s_r.csc[i], 1'b0};
              hit = 1'b1;
              if (s_r.cflag[i]) begin
                s_nxt.carmed[i] = 1'b1;
              end
            end else if (APB_REQ.paddr == choff + `CH_VH) begin
              rdat = {16'h0, sel_byte(s_r.cval[i], 1'b1)};
              hit = 1'b1;
            end else if (APB_REQ.paddr == choff + `CH_VL) begin
              rdat = {16'h0, sel_byte(s_r.cval[i], 1'b0)};
              hit = 1'b1;
            end
          end
          s_nxt.rsp.pslverr = !hit;
        end
      endcase
      s_nxt.rsp.prdata = rdat;
    end
    if (wr) begin
      case (APB_REQ.paddr)
        `OFF_SC: begin
          s_nxt.sc[6:0] = wb[6:0];
          // Clear only after a read saw the flag and no new wrap followed
          if (!wb[`SC_FLAG] && s_r.wrap_armed && !s_nxt.wrap_armed == 1'b0) begin
            s_nxt.sc[`SC_FLAG] = 1'b0;
          end
          s_nxt.wrap_armed = 1'b0;
        end
        `OFF_CNTH, `OFF_CNTL: begin
          s_nxt.cnt = 16'h0000;
          s_nxt.down = 1'b0;
        end
        `OFF_MODH: s_nxt.mod_hold = wb;
        `OFF_MODL: s_nxt.modv = {s_r.mod_hold, wb};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            choff = `OFF_CH_BASE + 12'(i) * `CH_STRIDE;
            if (APB_REQ.paddr == choff + `CH_SC) begin
              s_nxt.csc[i] = wb[6:1];
              s_nxt.hi_wr[i] = 1'b0;
              s_nxt.lo_wr[i] = 1'b0;
              if (!wb[7] && s_r.carmed[i] && s_nxt.carmed[i]) begin
                s_nxt.cflag[i] = 1'b0;
              end
              s_nxt.carmed[i] = 1'b0;
            end else if (APB_REQ.paddr == choff + `CH_VH ||
                         APB_REQ.paddr == choff + `CH_VL) begin
              if (APB_REQ.paddr == choff + `CH_VH) begin
                s_nxt.cbuf[i][15:8] = wb;
                s_nxt.hi_wr[i] = 1'b1;
              end else begin
                s_nxt.cbuf[i][7:0] = wb;
                s_nxt.lo_wr[i] = 1'b1;
              end
              if (s_nxt.hi_wr[i] && s_nxt.lo_wr[i]) begin
                s_nxt.hi_wr[i] = 1'b0;
                s_nxt.lo_wr[i] = 1'b0;
                if (clks == 2'b00) begin
                  s_nxt.cval[i] = s_nxt.cbuf[i];
                end else begin
                  s_nxt.pend[i] = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end
    s_nxt.wrap_irq = s_nxt.sc[`SC_FLAG] && s_nxt.sc[`SC_IE];
    for (int i = 0; i < NCH; i++) begin
      s_nxt.chan_irq[i] = s_nxt.cflag[i] && s_nxt.csc[i][0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign APB_RSP = s_r.rsp;
  assign CH_OUT = s_r.pout;
  assign CH_OE = s_r.poe;
  assign WRAP_IRQ = s_r.wrap_irq;
  assign CHAN_IRQ = s_r.chan_irq;

  wrap_irq_track_a: assert property (@(posedge CLK) disable iff (RESET)
    WRAP_IRQ == $past(s_nxt.sc[7] && s_nxt.sc[6], 1))
    else $error("wrap irq differs from flag and enable");
  reset_clear_a: assert property (@(posedge CLK)
    $fell(RESET) |-> s_r.sc == 8'h00 && CH_OE == '0)
    else $error("status control not cleared by reset");
  stop_counter_a: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.sc[4:3] == 2'b00 && !wr) |=> $stable(s_r.cnt))
    else $error("counter moved with clock off");
  up_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
    (!center && tick && at_term && !wr) |=> s_r.cnt == 16'h0000 && s_r.sc[7])
    else $error("up wrap missed");
  center_turn_a: assert property (@(posedge CLK) disable iff (RESET)
    (center && tick && !s_r.down && at_term && !wr) |=> s_r.down && s_r.sc[7])
    else $error("center turn missed");
  center_idle_a: assert property (@(posedge CLK) disable iff (RESET)
    (center && s_r.cval[0][15]) |=> s_r.pout[0] == $past(s_r.csc[0][2]))
    else $error("negative value not idle");
  quick_load_a: assert property (@(posedge CLK) disable iff (RESET)
    (wr && clks == 2'b00 && s_nxt.pend == s_r.pend && s_nxt.cbuf[0] != s_r.cbuf[0]
     && APB_REQ.paddr == `OFF_CH_BASE + `CH_VL && s_r.hi_wr[0]) |=> s_r.cval[0] == $past(s_nxt.cbuf[0]))
    else $error("buffer not loaded on second byte");
  edge_match_a: assert property (@(posedge CLK) disable iff (RESET)
    (!center && s_r.csc[0][5:4] == 2'b10 && tick && !at_term && cnt_next == s_r.cval[0])
    |=> s_r.cflag[0] && s_r.pout[0] == $past(s_r.csc[0][2]))
    else $error("edge match did not end duty");
  cov_edge_c: cover property (@(posedge CLK) disable iff (RESET) !center && $rose(CH_OUT[0]));
  cov_center_c: cover property (@(posedge CLK) disable iff (RESET) center && $rose(s_r.down));
  cov_clear_c: cover property (@(posedge CLK) disable iff (RESET) $fell(s_r.sc[7]));
endmodule : pulse_timer_module
`default_nettype wire

// file: design/pwm_timer_params.svh
// Constants of the pulse timer module: APB offsets, field positions, reset values.
// Assumes a 32-bit APB bus and one bus clock.
// What this block does
// - Edge period equals modulus plus one
// - Overflow sets output, match clears; polarity inverts
// - Value zero idle, above modulus always active
// - Clock off: value loads on second byte
// - Clock on: value loads at modulus-1 to modulus
// - Center mode counts up then down
// - Center: zero or negative value gives idle
// - Center: up match clears, down match sets
// - Reset clears status control and channel modes
// - Flag and enable drive interrupt request
// - Interrupt requests are active high
// - Read-then-write-zero clears; new event keeps flag
// - Up mode: wrap flag at modulus to zero
// - Center mode: wrap flag at the up-to-down reversal
// - Capture edge select sets channel flag
// - Compare match sets channel flag
// - Edge match or both center matches flag
// - Edge channels mix with capture and compare
// - Channel mode bits select per channel function
// - Clock select zero stops counter
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH
`define OFF_SC      12'h000
`define OFF_CNTH    12'h004
`define OFF_CNTL    12'h008
`define OFF_MODH    12'h00c
`define OFF_MODL    12'h010
`define OFF_CH_BASE 12'h020
`define CH_STRIDE   12'h010
`define CH_SC       12'h000
`define CH_VH       12'h004
`define CH_VL       12'h008
`define SC_FLAG     7
`define SC_IE       6
`define SC_CENTER   5
`define SC_CLKS_HI  4
`define SC_CLKS_LO  3
`define SC_PS_HI    2
`define SC_PS_LO    0
`define CSC_MS_HI   5
`define CSC_MS_LO   4
`define CSC_ELS_HI  3
`define CSC_ELS_LO  2
`define RESET_BYTE  8'h00
`endif

// file: design/pwm_timer_pkg.sv
// Types of the pulse timer module.
// Assumes the params header supplies the offsets.
package pwm_timer_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage : pwm_timer_pkg

// file: tb/pin_loads.sv
// Model of what hangs on the channel pins: a load per pin and an outside signal.
// Assumes one bus clock; the outside signal changes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pin_loads #(
  parameter int NCH = 2
) (
  // Clock
  input wire logic clk,
  // Pin drive from the timer
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe,
  // Level the outside world offers on a released pin
  input wire logic [NCH-1:0] src,
  // Level seen on the pins
  output logic [NCH-1:0] pin_lvl
);
  logic [NCH-1:0] src_r;
  // Registered so an outside edge never lands on the timer's sampling edge
  always @(posedge clk) begin
    src_r <= src;
  end
  // The timer wins only while it drives the pin
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : src_r[i];
    end
  end
endmodule : pin_loads
`default_nettype wire

// file: tb/timer_pwm_channels_and_irq_tb.sv
// Bench for the pulse timer module: APB tasks, duty counting on pin 0, flags.
// Assumes zero-wait APB answers and one counter step per enabled tick.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_timer_params.svh"
module timer_pwm_channels_and_irq_tb;
  import pwm_timer_pkg::*;
  logic clk;
  logic rst;
  apb_req_t req;
  apb_rsp_t rsp;
  logic fix_tick;
  logic ext_tick;
  logic [1:0] src;
  logic [1:0] pin;
  logic [1:0] ch_out;
  logic [1:0] ch_oe;
  logic wrap_irq;
  logic [1:0] chan_irq;
  logic [3:0] div_r;
  logic [31:0] rdat;
  logic serr;
  int errors;
  int n_compared;

  pulse_timer_module #(.NCH(2)) uut (
    .CLK(clk), .RESET(rst), .APB_REQ(req), .APB_RSP(rsp), .FIXED_TICK(fix_tick),
    .EXT_TICK(ext_tick), .CH_IN(pin), .CH_OUT(ch_out), .CH_OE(ch_oe),
    .WRAP_IRQ(wrap_irq), .CHAN_IRQ(chan_irq)
  );
  pin_loads #(.NCH(2)) loads (
    .clk(clk), .pin_out(ch_out), .pin_oe(ch_oe), .src(src), .pin_lvl(pin)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Fixed source ticks every 2nd cycle, external every 4th
  always @(posedge clk) begin
    div_r <= div_r + 4'h1;
    fix_tick <= div_r[0];
    ext_tick <= (div_r[1:0] == 2'h3);
  end

  task automatic complete_run();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held from setup until the edge that sees pready high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      errors++;
      complete_run();
    end
    rdat = rsp.prdata;
    serr = rsp.pslverr;
    req <= '0;
  endtask : xfer

  task automatic setv(input logic [15:0] v);
    xfer(`OFF_CH_BASE + `CH_VH, 1'b1, v[15:8]);
    xfer(`OFF_CH_BASE + `CH_VL, 1'b1, v[7:0]);
  endtask : setv

  // Lets a buffered value land, then counts high cycles over whole periods
  task automatic duty(input int n, input logic [31:0] exp);
    logic [31:0] k;
    k = 0;
    repeat (n) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      if (ch_out[0] === 1'b1) k++;
    end
    chk("pin 0 high cycles", exp, k);
  endtask : duty

  initial begin
    rst = 1'b1;
    req = '0;
    src = 2'b00;
    div_r = 4'h0;
    fix_tick = 1'b0;
    ext_tick = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pin enables after reset", 32'h0, {30'h0, ch_oe});
    xfer(`OFF_SC, 1'b0, 8'h00);
    chk("status control after reset", 32'h0, rdat);
    xfer(`OFF_CH_BASE, 1'b0, 8'h00);
    chk("channel control after reset", 32'h0, rdat);
    xfer(12'h0fc, 1'b0, 8'h00);
    chk("unmapped read error", 32'h1, {31'h0, serr});
    // Edge mode, modulus 9, high-true
    xfer(`OFF_MODH, 1'b1, 8'h00);
    xfer(`OFF_MODL, 1'b1, 8'h09);
    xfer(`OFF_CH_BASE, 1'b1, 8'h50);
    setv(16'h0003);
    chk("pin 0 enable", 32'h1, {31'h0, ch_oe[0]});
    for (int s = 1; s < 4; s++) begin
      xfer(`OFF_SC, 1'b1, {3'h0, s[1:0], 3'h0});
      duty(40 << (s - 1), 12 << (s - 1));
    end
    xfer(`OFF_SC, 1'b1, 8'h08);
    setv(16'h0000);
    duty(40, 0);
    setv(16'h000a);
    duty(40, 40);
    setv(16'h0003);
    xfer(`OFF_CH_BASE, 1'b1, 8'h58);
    duty(40, 28);
    xfer(`OFF_CH_BASE, 1'b1, 8'h50);
    xfer(`OFF_CH_BASE + `CH_VH, 1'b1, 8'h00);
    duty(40, 12);
    xfer(`OFF_CH_BASE + `CH_VL, 1'b1, 8'h05);
    duty(40, 20);
    // Channel 1 captures rising edges beside the running edge channel
    xfer(`OFF_CH_BASE + `CH_STRIDE, 1'b1, 8'h0a);
    src <= 2'b10;
    repeat (4) @(posedge clk);
    xfer(`OFF_CH_BASE + `CH_STRIDE, 1'b0, 8'h00);
    chk("capture flag", 32'h80, rdat & 32'h80);
    chk("channel 1 request", 32'h1, {31'h0, chan_irq[1]});
    // Wrap flag: a wrap between read and write keeps it set
    xfer(`OFF_SC, 1'b1, 8'h00);
    xfer(`OFF_SC, 1'b0, 8'h00);
    chk("wrap flag up mode", 32'h80, rdat);
    xfer(`OFF_SC, 1'b1, 8'h88);
    repeat (12) @(posedge clk);
    xfer(`OFF_SC, 1'b1, 8'h40);
    xfer(`OFF_SC, 1'b0, 8'h00);
    chk("flag kept after new event", 32'hc0, rdat);
    chk("wrap request", 32'h1, {31'h0, wrap_irq});
    xfer(`OFF_SC, 1'b1, 8'h40);
    xfer(`OFF_SC, 1'b0, 8'h00);
    chk("flag cleared", 32'h40, rdat);
    chk("wrap request off", 32'h0, {31'h0, wrap_irq});
    // Center mode, modulus 6, every active channel centered
    xfer(`OFF_MODH, 1'b1, 8'h00);
    xfer(`OFF_MODL, 1'b1, 8'h06);
    // Stopped count may sit above the new modulus; restart it from zero
    xfer(`OFF_CNTL, 1'b1, 8'h00);
    xfer(`OFF_CH_BASE + `CH_STRIDE, 1'b1, 8'h50);
    xfer(`OFF_SC, 1'b1, 8'h28);
    setv(16'h0002);
    duty(48, 16);
    setv(16'h8002);
    duty(48, 0);
    setv(16'h0007);
    duty(48, 48);
    xfer(`OFF_SC, 1'b0, 8'h00);
    chk("wrap flag center mode", 32'h80, rdat & 32'h80);
    complete_run();
  end
endmodule : timer_pwm_channels_and_irq_tb
`default_nettype wire
